/* serial_host_pkg.sv */
package serial_host_pkg;
    // =====================================================================
    // timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned BAUD_BPS        = 19_200;
    // nearest whole cycle, about 0.006 % off the nominal rate
    localparam int unsigned BIT_CYC         = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
    localparam int unsigned HALF_CYC        = BIT_CYC / 2;
    localparam int unsigned RESP_TIMEOUT_BITS = 40;
    localparam int unsigned RESP_TIMEOUT_CYC_DEF = RESP_TIMEOUT_BITS * BIT_CYC;
    localparam int unsigned TMR_W           = 20;

    // =====================================================================
    // character format
    localparam logic [3:0]  LONG_BITS       = 4'hB;   // start, 8 data, ninth, stop
    localparam logic [3:0]  SHORT_BITS      = 4'hA;   // start, 8 data, stop
    localparam logic [4:0]  SHORT_DEV_ADDR  = 5'h1F;  // this address always drops the ninth bit
    localparam int unsigned HIST_LEN        = 192;
    localparam logic [7:0]  HIST_LEN_B      = 8'hC0;
    localparam logic [7:0]  MAX_SHORT_READ  = 8'h03;

    // =====================================================================
    // device register map (reached through the serial link)
    localparam logic [5:0]  DEV_ALARM_STATUS     = 6'h04;
    localparam logic [5:0]  DEV_USER_BITS_MODE   = 6'h14;
    localparam logic [5:0]  DEV_LOOPBACK_CONTROL = 6'h35;
    localparam logic [5:0]  DEV_FIRMWARE_LEVEL   = 6'h3E;
    localparam logic [5:0]  DEV_FIRMWARE_VERSION = 6'h3F;

    // =====================================================================
    // own register map, byte wide
    localparam logic [8:0]  OFS_CTRL        = 9'h000;
    localparam logic [8:0]  OFS_DEV_ADDR    = 9'h001;
    localparam logic [8:0]  OFS_REG_ADDR    = 9'h002;
    localparam logic [8:0]  OFS_LEN         = 9'h003;
    localparam logic [8:0]  OFS_TX_DATA     = 9'h004;
    localparam logic [8:0]  OFS_STATUS      = 9'h005;
    localparam logic [8:0]  OFS_RX_COUNT    = 9'h006;
    localparam int unsigned BUF_BASE_BIT    = 8;      // addr bit 8 set: receive buffer

    localparam int unsigned CTRL_GO         = 0;
    localparam int unsigned CTRL_READ       = 1;
    localparam int unsigned CTRL_SHORT      = 2;
    localparam int unsigned CTRL_CLEAR      = 3;

    localparam int unsigned STAT_BUSY       = 0;
    localparam int unsigned STAT_DONE       = 1;
    localparam int unsigned STAT_ERR_LEN    = 2;
    localparam int unsigned STAT_ERR_TMO    = 3;
    localparam int unsigned STAT_ERR_FRAME  = 4;

    localparam logic [2:0]  CFG_RST         = 3'h0;
    localparam logic [4:0]  DEV_RST         = 5'h00;
    localparam logic [5:0]  REG_RST         = 6'h00;
    localparam logic [7:0]  LEN_RST         = 8'h01;
    localparam logic [7:0]  BYTE_RST        = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX_WAIT, ST_RX} state_t;
endpackage : serial_host_pkg

/* serial_host_ctrl.sv */
// Notes on behaviour
// - each transaction addresses exactly one device register, never several.
// - a register transaction is three, four or five bytes, by width and direction.
// - long history read is two bytes out then 192 bytes back.
// - controller always sends the address byte first; device never starts.
// - normal character: zero start, eight data LSB first, ninth bit, one stop.
// - ninth bit is one in address byte, zero in register and data bytes.
// - device addresses 0 to 30 use the eleven-bit character.
// - address 31 or strapped drive-enable low uses the ten-bit character.
// - address byte holds 5-bit address in bits 4..0, bits 7..5 zero.
// - register byte: clear flag bit 7, bit 6 zero, register in 5..0.
// - third byte either way; fourth and fifth bytes only device to controller.
// - multi-byte values go least significant byte first, bits LSB first.
// - both serial lines run at 19.2 kbit per second.
module serial_host_ctrl #(
    parameter int unsigned RESP_TIMEOUT_CYC = serial_host_pkg::RESP_TIMEOUT_CYC_DEF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    input  wire logic [8:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       rxd_i,
    output logic            txd_o,
    output logic            busy_o
);
    import serial_host_pkg::*;

    // =====================================================================
    // elaboration checks
    if (BIT_CYC < 4) begin : g_chk_bit
        $error("bit time too short for this clock");
    end
    if (RESP_TIMEOUT_CYC <= BIT_CYC || RESP_TIMEOUT_CYC >= (1 << TMR_W)) begin : g_chk_tmo
        $error("response timeout out of range");
    end

    localparam logic [TMR_W-1:0] BIT_LD  = TMR_W'(BIT_CYC - 1);
    localparam logic [TMR_W-1:0] HALF_LD = TMR_W'(HALF_CYC - 1);
    localparam logic [TMR_W-1:0] TMO_LD  = TMR_W'(RESP_TIMEOUT_CYC - 1);

    // one character, start bit in bit 0 so it leaves first
    function automatic logic [10:0] make_frame(input logic [7:0] b, input logic ninth,
                                               input logic short_fmt);
        make_frame = short_fmt ? {2'b11, b, 1'b0} : {1'b1, ninth, b, 1'b0};
    endfunction : make_frame

    // =====================================================================
    // state
    state_t          st_q;
    logic [TMR_W-1:0] tmr_q;
    logic [3:0]      bit_q;
    logic [1:0]      byte_q;
    logic [7:0]      rx_cnt_q;
    logic [9:0]      sh_q;
    logic [7:0]      rxsh_q;
    logic            txd_q;
    logic [2:0]      cfg_q;          // clear, short, read
    logic [4:0]      dev_q;
    logic [5:0]      reg_q;
    logic [7:0]      len_q;
    logic [7:0]      txb_q;
    logic            done_q, err_len_q, err_tmo_q, err_frame_q;
    logic            busy_q;
    logic [7:0]      rdata_q;
    logic            rx_s1_q, rx_s2_q, rx_s3_q;
    logic [7:0]      buf_q [HIST_LEN];

    // =====================================================================
    // decode
    wire       wr_ctrl   = ce_i & wr_i & (addr_i == OFS_CTRL);
    wire       wr_stat   = ce_i & wr_i & (addr_i == OFS_STATUS);
    wire       idle      = (st_q == ST_IDLE);
    wire       go        = wr_ctrl & wdata_i[CTRL_GO] & idle;
    wire       go_read   = wdata_i[CTRL_READ];
    // only the widths the device has: 1..3 bytes, or the long history block
    wire       len_ok    = ~go_read | (len_q != BYTE_RST & len_q <= MAX_SHORT_READ)
                           | (len_q == HIST_LEN_B);
    wire       accept    = go & len_ok;
    wire       refuse    = go & ~len_ok;
    wire       go_short  = wdata_i[CTRL_SHORT] | (dev_q == SHORT_DEV_ADDR);
    wire       cur_short = cfg_q[1] | (dev_q == SHORT_DEV_ADDR);
    wire [3:0] nbits     = cur_short ? SHORT_BITS : LONG_BITS;
    wire       tick      = (tmr_q == '0);
    wire       rx_fall   = rx_s3_q & ~rx_s2_q;
    wire [1:0] tx_last   = cfg_q[0] ? 2'd1 : 2'd2;
    wire [7:0] addr_byte = {3'b000, dev_q};
    wire [7:0] reg_byte  = {cfg_q[2], 1'b0, reg_q};
    wire [7:0] next_byte = (byte_q == 2'd0) ? reg_byte : txb_q;
    wire [10:0] frm_addr = make_frame(addr_byte, 1'b1, go_short);
    wire [10:0] frm_next = make_frame(next_byte, 1'b0, cur_short);
    wire [3:0] stop_idx  = nbits - 4'd1;
    wire       rx_stop   = (st_q == ST_RX) & tick & (bit_q == stop_idx);
    wire       rx_last   = (rx_cnt_q + 8'd1) == len_q;
    wire       buf_sel   = addr_i[BUF_BASE_BIT] & (addr_i[7:0] < HIST_LEN_B);
    wire [7:0] status_v  = {3'b000, err_frame_q, err_tmo_q, err_len_q, done_q, ~idle};
    wire [7:0] rd_mux    = buf_sel                    ? buf_q[addr_i[7:0]] :
                           (addr_i == OFS_CTRL)       ? {4'h0, cfg_q[2:1], cfg_q[0], 1'b0} :
                           (addr_i == OFS_DEV_ADDR)   ? {3'b000, dev_q} :
                           (addr_i == OFS_REG_ADDR)   ? {2'b00, reg_q} :
                           (addr_i == OFS_LEN)        ? len_q :
                           (addr_i == OFS_TX_DATA)    ? txb_q :
                           (addr_i == OFS_STATUS)     ? status_v :
                           (addr_i == OFS_RX_COUNT)   ? rx_cnt_q : 8'h00;
    wire       tx_end    = (st_q == ST_TX) & tick & (bit_q == 4'd0) & (byte_q == tx_last);
    wire       set_done  = (tx_end & ~cfg_q[0]) | (rx_stop & rx_last)
                           | ((st_q == ST_RX_WAIT) & tick & ~rx_fall);
    wire       set_tmo   = (st_q == ST_RX_WAIT) & tick & ~rx_fall;
    wire       false_st  = (st_q == ST_RX) & tick & (bit_q == 4'd0) & rx_s2_q;
    wire       set_frame = (rx_stop & ~rx_s2_q) | false_st;
    // every way back to idle; busy_o has to come from a flop, so it follows these
    wire       leave     = set_done | false_st;

    // =====================================================================
    // line input synchroniser; the second stage feeds logic, the third only the falling-edge detect
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else if (ce_i) begin
            rx_s1_q <= rxd_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    // software-written setup, held steady while a transaction runs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dev_q <= DEV_RST;
            reg_q <= REG_RST;
            len_q <= LEN_RST;
            txb_q <= BYTE_RST;
            cfg_q <= CFG_RST;
        end else if (ce_i & wr_i & idle) begin
            if (addr_i == OFS_DEV_ADDR) dev_q <= wdata_i[4:0];
            if (addr_i == OFS_REG_ADDR) reg_q <= wdata_i[5:0];
            if (addr_i == OFS_LEN)      len_q <= wdata_i;
            if (addr_i == OFS_TX_DATA)  txb_q <= wdata_i;
            if (accept)                 cfg_q <= {wdata_i[CTRL_CLEAR], wdata_i[CTRL_SHORT],
                                                  wdata_i[CTRL_READ]};
        end
    end

    // sticky status: a hardware set beats a clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_q      <= 1'b0;
            err_len_q   <= 1'b0;
            err_tmo_q   <= 1'b0;
            err_frame_q <= 1'b0;
            busy_q      <= 1'b0;
        end else if (ce_i) begin
            done_q      <= set_done  | (done_q      & ~accept & ~(wr_stat & wdata_i[STAT_DONE]));
            err_len_q   <= refuse    | (err_len_q   & ~accept & ~(wr_stat & wdata_i[STAT_ERR_LEN]));
            err_tmo_q   <= set_tmo   | (err_tmo_q   & ~accept & ~(wr_stat & wdata_i[STAT_ERR_TMO]));
            err_frame_q <= set_frame | (err_frame_q & ~accept & ~(wr_stat & wdata_i[STAT_ERR_FRAME]));
            busy_q      <= accept | (busy_q & ~leave);
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= BYTE_RST;
        end else if (ce_i) begin
            rdata_q <= rd_i ? rd_mux : BYTE_RST;
        end
    end

    // receive buffer, lowest byte of the value lands at index 0
    always_ff @(posedge clk_i) begin
        if (ce_i & rx_stop) begin
            buf_q[rx_cnt_q] <= rxsh_q;
        end
    end

    // =====================================================================
    // transaction sequencer; one timer serves bit timing and response timeout
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q     <= ST_IDLE;
            tmr_q    <= '0;
            bit_q    <= 4'h0;
            byte_q   <= 2'd0;
            rx_cnt_q <= BYTE_RST;
            sh_q     <= '1;
            rxsh_q   <= BYTE_RST;
            txd_q    <= 1'b1;
        end else if (ce_i) begin
            unique case (st_q)
                ST_IDLE: begin
                    txd_q <= 1'b1;
                    if (accept) begin
                        st_q     <= ST_TX;
                        txd_q    <= frm_addr[0];
                        sh_q     <= frm_addr[10:1];
                        // start bit is out already; the rest, stop bit included, follow
                        bit_q    <= (go_short ? SHORT_BITS : LONG_BITS) - 4'd1;
                        byte_q   <= 2'd0;
                        rx_cnt_q <= BYTE_RST;
                        tmr_q    <= BIT_LD;
                    end
                end
                ST_TX: begin
                    tmr_q <= tick ? BIT_LD : tmr_q - 1'b1;
                    if (tick & (bit_q != 4'd0)) begin
                        txd_q <= sh_q[0];
                        sh_q  <= {1'b1, sh_q[9:1]};
                        bit_q <= bit_q - 4'd1;
                    end else if (tick & (byte_q != tx_last)) begin
                        txd_q  <= frm_next[0];
                        sh_q   <= frm_next[10:1];
                        bit_q  <= nbits - 4'd1;
                        byte_q <= byte_q + 2'd1;
                    end else if (tick) begin
                        st_q  <= cfg_q[0] ? ST_RX_WAIT : ST_IDLE;
                        tmr_q <= TMO_LD;
                    end
                end
                ST_RX_WAIT: begin
                    tmr_q <= tmr_q - 1'b1;
                    if (rx_fall) begin
                        st_q  <= ST_RX;
                        bit_q <= 4'h0;
                        tmr_q <= HALF_LD;
                    end else if (tick) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_RX: begin
                    tmr_q <= tick ? BIT_LD : tmr_q - 1'b1;
                    if (tick) begin
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == 4'd0 && rx_s2_q) begin
                            st_q <= ST_IDLE;                      // false start
                        end else if (bit_q >= 4'd1 && bit_q <= 4'd8) begin
                            rxsh_q <= {rx_s2_q, rxsh_q[7:1]};
                        end else if (bit_q == stop_idx) begin
                            rx_cnt_q <= rx_cnt_q + 8'd1;
                            st_q     <= rx_last ? ST_IDLE : ST_RX_WAIT;
                            tmr_q    <= TMO_LD;
                        end
                    end
                end
            endcase
        end
    end

    assign txd_o   = txd_q;
    assign busy_o  = busy_q;
    assign rdata_o = rdata_q;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_IDLE_MARK: assert property (idle && $past(idle) |-> txd_o)
        else $error("line not at mark while idle");
    AST_ADDR_FIRST: assert property (accept |=> st_q == ST_TX && !txd_o && byte_q == 2'd0)
        else $error("transaction did not open with address start bit");
    AST_ADDR_LAYOUT: assert property (accept && !go_short |=> sh_q[8] && sh_q[7:5] == 3'b000)
        else $error("address byte layout wrong");
    AST_LONG_CHAR: assert property (accept && !go_short |=> bit_q == 4'd10)
        else $error("eleven-bit character not used");
    AST_SHORT_CHAR: assert property (accept && go_short |=> bit_q == 4'd9 && sh_q[8])
        else $error("ten-bit character not used");
    AST_REG_BYTE: assert property (st_q == ST_TX && tick && bit_q == 4'd0 && byte_q == 2'd0
                                   && !cur_short |=> !txd_o && !sh_q[8] && !sh_q[6])
        else $error("register byte layout wrong");
    AST_DATA_NINTH: assert property (st_q == ST_TX && tick && bit_q == 4'd0 && byte_q == 2'd1
                                     && !cfg_q[0] && !cur_short |=> !sh_q[8])
        else $error("data byte ninth bit not zero");
    // the timer is not reloaded in idle, so the opening start bit is left out here
    AST_BIT_TIME: assert property (st_q == ST_TX && $past(st_q == ST_TX) && $changed(txd_o)
                                   |-> $past(tick))
        else $error("line changed inside a bit time");
    AST_BUSY_FLOP: assert property (busy_o == !idle)
        else $error("busy output out of step with the sequencer");
    AST_ONE_WRITE: assert property (st_q == ST_TX |-> byte_q <= tx_last)
        else $error("more than one data byte sent");
    AST_ONE_REG: assert property (!idle && $past(!idle) |-> $stable(reg_q) && $stable(dev_q))
        else $error("target changed during a transaction");
    AST_RX_LEN: assert property (st_q == ST_RX |-> rx_cnt_q < len_q)
        else $error("received beyond requested length");
    AST_RX_ORDER: assert property (rx_stop |=> rx_cnt_q == $past(rx_cnt_q) + 8'd1)
        else $error("receive index did not advance by one");
    AST_LONG_READ: assert property (rx_stop && rx_last && len_q == HIST_LEN_B
                                    |=> rx_cnt_q == HIST_LEN_B && idle)
        else $error("history read length wrong");

    COV_WRITE: cover property (tx_end && !cfg_q[0]);
    COV_READ3: cover property (rx_stop && rx_last && len_q == 8'd3);
    COV_HIST: cover property (rx_stop && rx_last && len_q == HIST_LEN_B);
    COV_TMO: cover property (set_tmo);
endmodule : serial_host_ctrl

/* serial_dev_model.sv */
// =====================================================================
// behavioural monitor device on the far end of the serial link
module serial_dev_model
    import serial_host_pkg::*;
#(
    parameter logic [4:0] MY_ADDR    = 5'h05,
    parameter logic [7:0] LEVEL_VAL  = 8'hFB,  // arbitrary value
    parameter logic [7:0] VER_VAL    = 8'h0B,  // arbitrary value
    parameter logic [7:0] ALARM_INIT = 8'h5A,
    parameter bit         STRAP_LOW  = 1'b0
) (
    input  wire logic rx_i,
    output logic      tx_o,
    output logic      line_driver_enable_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         BIT_NS   = BIT_CYC * 40;
    localparam bit         LONG_FMT = !STRAP_LOW && (MY_ADDR != 5'h1F);
    localparam logic [4:0] EFF_ADDR = STRAP_LOW ? 5'h00 : MY_ADDR;
    logic [8:0] log_q[$];
    logic [7:0] user_bits_q, loop_q, msg_q, act_q, alarm_q, v;
    logic [8:0] a_c, r_c, d_c;
    logic       frame_ok;

    // sample mid-bit; a low stop bit marks the frame bad
    task automatic get_char(output logic [8:0] c);
        c = 9'h000;
        @(negedge rx_i);
        #(BIT_NS / 2);
        if (rx_i !== 1'b0) frame_ok = 1'b0;
        for (int i = 0; i < 8; i++) begin
            #(BIT_NS);
            c[i] = rx_i;
        end
        if (LONG_FMT) begin
            #(BIT_NS);
            c[8] = rx_i;
        end
        #(BIT_NS);
        if (rx_i !== 1'b1) frame_ok = 1'b0;
        log_q.push_back(c);
    endtask : get_char

    // own start and stop bits, ninth bit always zero
    task automatic put_char(input logic [7:0] b);
        line_driver_enable_o = 1'b1;
        tx_o = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            tx_o = b[i];
            #(BIT_NS);
        end
        if (LONG_FMT) begin
            tx_o = 1'b0;
            #(BIT_NS);
        end
        tx_o = 1'b1;
        #(BIT_NS);
        line_driver_enable_o = 1'b0;
    endtask : put_char

    // one register per transaction; line stays idle high when not addressed
    initial begin
        tx_o = 1'b1;
        line_driver_enable_o = 1'b0;
        frame_ok = 1'b1;
        {user_bits_q, loop_q, msg_q, act_q} = 32'h0000_0000;
        alarm_q = ALARM_INIT;
        forever begin
            get_char(a_c);
            if (a_c[4:0] == EFF_ADDR && a_c[7:5] == 3'h0 && (!LONG_FMT || a_c[8])) begin
                get_char(r_c);
                if (r_c[5:0] inside {6'h14, 6'h35, 6'h19, 6'h1F}) begin
                    get_char(d_c);
                    case (r_c[5:0])
                        6'h14:   user_bits_q = d_c[7:0];
                        6'h35:   loop_q = d_c[7:0];
                        6'h19:   msg_q = d_c[7:0];
                        default: act_q = d_c[7:0];
                    endcase
                end else begin
                    #(2 * BIT_NS);
                    case (r_c[5:0])
                        6'h04:   v = alarm_q;
                        6'h3E:   v = LEVEL_VAL;
                        6'h3F:   v = VER_VAL;
                        default: v = 8'h00;
                    endcase
                    put_char(v);
                    if (r_c[5:0] == 6'h04) alarm_q = 8'h00;
                end
            end
        end
    end
endmodule : serial_dev_model

/* multidrop_serial_register_access_tb.sv */
module multidrop_serial_register_access_tb
    import serial_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_i, rst_b_i, wr_i, rd_i, txd_o, busy_o, rxd, drv_en, ce;
    logic [8:0] addr_i;
    logic [7:0] wdata_i, rdata_o, got;
    int         n_mismatch, n_tests;

    // =====================================================================
    // clock, reset, watchdog
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        // the two link transfers need about 89000 cycles; keep the run under 100000
        #(99000 * 40);
        n_mismatch++;
        close_out();
    end

    serial_host_ctrl #(.RESP_TIMEOUT_CYC(15624)) u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rxd_i(rxd), .txd_o(txd_o), .busy_o(busy_o)
    );
    serial_dev_model u_dev (.rx_i(txd_o), .tx_o(rxd), .line_driver_enable_o(drv_en));

    // =====================================================================
    // shared helpers
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic bus_wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : bus_wr

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : bus_rd

    task automatic wait_done();
        @(posedge clk_i);
        #1 chk("busy", 9'h001, {8'h00, busy_o});
        for (int i = 0; i < 80000 && busy_o !== 1'b0; i++) @(posedge clk_i);
        #1 chk("busy end", 9'h000, {8'h00, busy_o});
    endtask : wait_done

    // =====================================================================
    // scenarios
    task automatic t_reset_map();
        logic [7:0] exp_r [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            bus_rd(9'(i), got);
            chk("reset reg", {1'b0, exp_r[i]}, {1'b0, got});
        end
        bus_wr(9'h007, 8'hFF);
        bus_rd(9'h007, got);
        chk("unmapped", 9'h000, {1'b0, got});
        // a write while the clock enable is low must leave the length untouched
        ce <= 1'b0;
        bus_wr(OFS_LEN, 8'h02);
        ce <= 1'b1;
        bus_rd(OFS_LEN, got);
        chk("frozen len", 9'h001, {1'b0, got});
    endtask : t_reset_map

    // a read of four bytes is not a legal register width
    task automatic t_len_refused();
        bus_wr(OFS_LEN, 8'h04);
        bus_wr(OFS_CTRL, 8'h03);
        repeat (20) @(posedge clk_i);
        #1 chk("idle txd", 9'h001, {8'h00, txd_o});
        chk("idle busy", 9'h000, {8'h00, busy_o});
        bus_rd(OFS_STATUS, got);
        chk("err_len", 9'h004, {1'b0, got});
        bus_wr(OFS_STATUS, 8'hFF);
        bus_rd(OFS_STATUS, got);
        chk("status clear", 9'h000, {1'b0, got});
    endtask : t_len_refused

    task automatic t_write();
        u_dev.log_q.delete();
        bus_wr(OFS_DEV_ADDR, 8'h05);
        bus_wr(OFS_REG_ADDR, 8'h14);
        bus_wr(OFS_TX_DATA, 8'hA5);
        bus_wr(OFS_CTRL, 8'h01);
        wait_done();
        chk("log size", 9'h003, 9'(u_dev.log_q.size()));
        chk("addr char", 9'h105, u_dev.log_q[0]);
        chk("reg char", 9'h014, u_dev.log_q[1]);
        chk("data char", 9'h0A5, u_dev.log_q[2]);
        chk("framing", 9'h001, {8'h00, u_dev.frame_ok});
        chk("user bits", 9'h0A5, {1'b0, u_dev.user_bits_q});
        bus_rd(OFS_STATUS, got);
        chk("write done", 9'h002, {1'b0, got});
    endtask : t_write

    task automatic t_read_clear();
        u_dev.log_q.delete();
        bus_wr(OFS_REG_ADDR, 8'h04);
        bus_wr(OFS_LEN, 8'h01);
        bus_wr(OFS_CTRL, 8'h0B);
        wait_done();
        chk("log size", 9'h002, 9'(u_dev.log_q.size()));
        chk("clear char", 9'h084, u_dev.log_q[1]);
        bus_rd(9'h100, got);
        chk("rx byte", 9'h05A, {1'b0, got});
        bus_rd(OFS_RX_COUNT, got);
        chk("rx count", 9'h001, {1'b0, got});
        bus_rd(OFS_STATUS, got);
        chk("read done", 9'h002, {1'b0, got});
        bus_rd(OFS_CTRL, got);
        chk("ctrl cfg", 9'h00A, {1'b0, got});
        // the device clears and drops its driver only after its own stop bit
        repeat (BIT_CYC) @(posedge clk_i);
        chk("alarm cleared", 9'h000, {1'b0, u_dev.alarm_q});
        chk("driver off", 9'h000, {8'h00, drv_en});
    endtask : t_read_clear

    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    // =====================================================================
    // main sequence
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rst_b_i = 1'b0;
        ce = 1'b1;
        addr_i = 9'h000;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset_map();
        t_len_refused();
        t_write();
        t_read_clear();
        close_out();
    end
endmodule : multidrop_serial_register_access_tb
